// file: logic/clm_pkg.sv
package clm_pkg;

   // ***************************************************
   // Register map and layout
   // ***************************************************
   localparam logic [7:0]  ADDR_INPUT_CFG = 8'h00;
   localparam logic [7:0]  ADDR_CELL_CFG0 = 8'h04;
   localparam logic [7:0]  ADDR_CELL_CFG1 = 8'h08;
   localparam logic [7:0]  ADDR_CELL_CFG2 = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS    = 8'h10;

   localparam int          IN_DED_CAPTURE_BIT = 0;
   localparam int          IN_DED_LATCH_BIT   = 1;
   localparam int          IN_PIN_CAPTURE_BIT = 2;
   localparam int          IN_PIN_LATCH_BIT   = 3;
   localparam int          STATUS_OUT_LSB     = 8;
   localparam int          STATUS_PWRUP_BIT   = 18;

   localparam logic [31:0] INPUT_CFG_RESET = 32'h0000_000F;
   localparam logic [31:0] CELL_CFG_RESET  = 32'h4444_4444;
   localparam logic [31:0] CELL_CFG2_RESET = 32'h0000_0044;
   localparam logic [31:0] CELL_CFG2_MASK  = 32'h0000_00FF;

   // ***************************************************
   // Fabric sizes
   // ***************************************************
   localparam int          N_DED      = 10;
   localparam int          N_BURIED   = 8;
   localparam int          N_OUT      = 10;
   localparam int          N_CELLS    = 18;
   localparam int          OUT_FIRST  = 14;
   localparam int          BURIED_FIRST = 0;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int          CLK_PERIOD_PS  = 5000;
   localparam int          PWRUP_TIME_NS  = 10000;
   localparam int          PWRUP_CYCLES   = (PWRUP_TIME_NS * 1000) / CLK_PERIOD_PS;

   // ***************************************************
   // Types
   // ***************************************************
   typedef struct packed {
      logic latch_sel;
      logic capture_enable_sel;
   } clm_in_cfg_type;

   typedef struct packed {
      logic clock_source_sel;
      logic output_timing_sel;
      logic data_polarity_sel;
      logic enable_term_polarity_sel;
   } clm_cell_cfg_type;

   typedef enum logic [1:0] {
      CELL_COMB,
      CELL_SUM_CLOCK,
      CELL_SHARED_CLOCK
   } clm_cell_mode_type;

   function automatic logic [31:0] apply_be(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic clm_cell_mode_type cell_mode(input clm_cell_cfg_type c);
      clm_cell_mode_type m;
      m = CELL_COMB;
      if (!c.output_timing_sel) begin
         m = c.clock_source_sel ? CELL_SHARED_CLOCK : CELL_SUM_CLOCK;
      end
      return m;
   endfunction

endpackage

// file: logic/clm_input_group.sv
module clm_input_group
   import clm_pkg::*;
#(
   parameter int W = 10
) (
   input  wire logic           clk_in,       // System clock.
   input  wire logic           reset_in,     // Synchronous reset.
   input  wire clm_in_cfg_type cfg_in,       // Group mode.
   input  wire logic           cap_level_in, // Input capture clock level.
   input  wire logic           cap_rise_in,  // Input capture clock rising edge.
   input  wire logic [W-1:0]   pins_in,      // Pin values.
   output logic      [W-1:0]   cells_out     // Values presented to the array.
);

   logic [W-1:0] hold_r;
   logic         capture;
   logic         latched;

   // Latch 0 with capture 1 is not a valid setting; it behaves as direct.
   assign capture = ~cfg_in.capture_enable_sel & ~(cfg_in.latch_sel & 1'b0);
   assign latched = capture & ~cfg_in.latch_sel;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hold_r <= '0;
      end else if (latched && cap_level_in) begin
         hold_r <= pins_in;
      end else if (capture && !latched && cap_rise_in) begin
         hold_r <= pins_in;
      end
   end

   always_comb begin
      if (!capture) begin
         cells_out = pins_in;
      end else if (latched && cap_level_in) begin
         cells_out = pins_in;
      end else begin
         cells_out = hold_r;
      end
   end

endmodule

// file: logic/clm_cell.sv
module clm_cell
   import clm_pkg::*;
(
   input  wire logic             clk_in,      // System clock.
   input  wire logic             reset_in,    // Synchronous reset.
   input  wire logic             clear_in,    // Shared register clear, active high.
   input  wire clm_cell_cfg_type cfg_in,      // Cell configuration.
   input  wire logic             data_in,     // Data sum term.
   input  wire logic             enable_in,   // Enable sum term, raw polarity.
   input  wire logic             oc_rise_in,  // Shared output clock rising edge.
   output logic                  reg_out,     // Register state.
   output logic                  value_out    // Cell output before the pin buffer.
);

   clm_cell_mode_type mode;
   logic              term_e;
   logic              term_d;
   logic              term_e_prev_r;
   logic              q_r;

   assign mode   = cell_mode(cfg_in);
   // Polarity sits ahead of the register, so a cleared register is zero whatever the setting.
   assign term_d = data_in ^ cfg_in.data_polarity_sel;
   assign term_e = enable_in ^ cfg_in.enable_term_polarity_sel;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         term_e_prev_r <= 1'b0;
      end else begin
         term_e_prev_r <= term_e;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || clear_in) begin
         q_r <= 1'b0;
      end else if (mode == CELL_SHARED_CLOCK && oc_rise_in && term_e) begin
         q_r <= term_d;
      end else if (mode == CELL_SUM_CLOCK && term_e && !term_e_prev_r) begin
         q_r <= term_d;
      end
   end

   // The clear masks the register at once so it acts without waiting for an edge.
   assign reg_out   = q_r & ~clear_in;
   assign value_out = (mode == CELL_COMB) ? term_d : reg_out;

endmodule

// file: logic/clm_fabric.sv
// Notes on behaviour
// - Two input groups, dedicated inputs and pin inputs, each set as a whole.
// - Each input group is direct, latched or registered.
// - Latched group is transparent while input capture clock is high.
// - Registered group samples pins on input capture clock rising edge.
// - Four input mode bits, capture and latch select per group, in configuration.
// - Capture select picks direct versus captured; latch select picks latch or register.
// - Latch1/capture1 direct, latch0/capture0 latched, latch1/capture0 registered.
// - Eight buried cells feed only the array, never pins.
// - Ten output cells feed the array and drive pins.
// - Each cell has its own four configuration bits.
// - Output cells are numbered 14 to 23, buried cells 0 to 7.
// - Shared clock mode: shared output clock, enable term is clock enable.
// - Sum clock mode: register always enabled, enable term is its clock.
// - Combinational mode bypasses the register; buried gives complement terms.
// - Output cell pin polarity chosen by data polarity bit.
// - Every enable term polarity chosen by enable term polarity bit; pin enable product terms pass with no polarity bit.
// - Each output pin driver enabled by its own enable product term.
// - One active high reset term clears all cell registers to zero.
// - Cleared register shows as one at its pin through the inverting buffer.
// - Direct feedback always present; pin feedback valid only while driving.
// - The shared reset comes from a dedicated reset product term.
// - After power-up all registers are cleared within 10 microseconds.
module clm_fabric
   import clm_pkg::*;
(
   input  wire logic                clk_in,               // 200 MHz clock.
   input  wire logic                reset_in,             // Synchronous reset, active high.
   input  wire logic [7:0]          avs_address_in,       // Byte address.
   input  wire logic                avs_read_in,          // Read request.
   input  wire logic                avs_write_in,         // Write request.
   input  wire logic [31:0]         avs_writedata_in,     // Write data.
   input  wire logic [3:0]          avs_byteenable_in,    // Byte enables.
   output logic      [31:0]         avs_readdata_out,     // Read data.
   output logic                     avs_waitrequest_out,  // Wait request.
   input  wire logic                input_capture_clock_in, // Input capture clock level.
   input  wire logic                shared_output_clock_in, // Shared output clock level.
   input  wire logic [N_DED-1:0]    ded_pins_in,          // Dedicated input pins.
   input  wire logic [N_OUT-1:0]    io_pins_in,           // Pin levels seen at the pads.
   output logic      [N_OUT-1:0]    io_pins_out,          // Pin drive values.
   output logic      [N_OUT-1:0]    io_pins_oe_out,       // Pin drive enables.
   input  wire logic [N_CELLS-1:0]  data_terms_in,        // Data sum terms.
   input  wire logic [N_CELLS-1:0]  enable_terms_in,      // Enable sum terms.
   input  wire logic [N_OUT-1:0]    oe_terms_in,          // Pin enable product terms.
   input  wire logic                reset_term_in,        // Shared register reset term.
   output logic      [N_DED-1:0]    ded_cells_out,        // Dedicated input cells to array.
   output logic      [N_OUT-1:0]    pin_cells_out,        // Pin input cells to array.
   output logic      [N_OUT-1:0]    pin_feedback_valid_out, // Pin feedback is meaningful.
   output logic      [N_CELLS-1:0]  cell_feedback_out,    // Direct cell feedback to array.
   output logic                     pwrup_busy_out        // Power-up clear in progress.
);

   // ***************************************************
   // Power-up clear
   // ***************************************************
   localparam int PWRUP_W = $clog2(PWRUP_CYCLES + 1);

   logic [PWRUP_W-1:0] pwrup_cnt_r;
   logic               pwrup_busy_r;
   logic               clear_all;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pwrup_cnt_r  <= '0;
         pwrup_busy_r <= 1'b1;
      end else if (pwrup_busy_r) begin
         if (pwrup_cnt_r == PWRUP_W'(PWRUP_CYCLES - 1)) begin
            pwrup_busy_r <= 1'b0;
         end
         pwrup_cnt_r <= pwrup_cnt_r + PWRUP_W'(1);
      end
   end

   assign clear_all      = reset_term_in | pwrup_busy_r;
   assign pwrup_busy_out = pwrup_busy_r;

   // ***************************************************
   // Clock edge detection
   // ***************************************************
   logic icap_prev_r;
   logic oc_prev_r;
   logic icap_rise;
   logic oc_rise;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         icap_prev_r <= 1'b0;
         oc_prev_r   <= 1'b0;
      end else begin
         icap_prev_r <= input_capture_clock_in;
         oc_prev_r   <= shared_output_clock_in;
      end
   end

   assign icap_rise = input_capture_clock_in & ~icap_prev_r;
   assign oc_rise   = shared_output_clock_in & ~oc_prev_r;

   // ***************************************************
   // Register bus slave
   // ***************************************************
   logic [31:0] input_cfg_r;
   logic [31:0] cell_cfg0_r;
   logic [31:0] cell_cfg1_r;
   logic [31:0] cell_cfg2_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        req;
   logic        wr_take;
   logic [N_CELLS-1:0] cell_regs;

   assign req                 = avs_read_in | avs_write_in;
   // One wait cycle: the answer comes at the second edge of every request.
   assign avs_waitrequest_out = req & ~ack_r;
   assign wr_take             = avs_write_in & ack_r;
   assign avs_readdata_out    = rdata_r;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   always_comb begin
      rdata_nxt = '0;
      case (avs_address_in)
         ADDR_INPUT_CFG: begin
            rdata_nxt = input_cfg_r;
         end
         ADDR_CELL_CFG0: begin
            rdata_nxt = cell_cfg0_r;
         end
         ADDR_CELL_CFG1: begin
            rdata_nxt = cell_cfg1_r;
         end
         ADDR_CELL_CFG2: begin
            rdata_nxt = cell_cfg2_r;
         end
         ADDR_STATUS: begin
            rdata_nxt[N_CELLS-1:0]    = cell_regs;
            rdata_nxt[STATUS_PWRUP_BIT] = pwrup_busy_r;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_r <= '0;
      end else if (avs_read_in && !ack_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         input_cfg_r <= INPUT_CFG_RESET;
         cell_cfg0_r <= CELL_CFG_RESET;
         cell_cfg1_r <= CELL_CFG_RESET;
         cell_cfg2_r <= CELL_CFG2_RESET;
      end else if (wr_take) begin
         case (avs_address_in)
            ADDR_INPUT_CFG: begin
               input_cfg_r <= apply_be(input_cfg_r, avs_writedata_in,
                                       avs_byteenable_in) & INPUT_CFG_RESET;
            end
            ADDR_CELL_CFG0: begin
               cell_cfg0_r <= apply_be(cell_cfg0_r, avs_writedata_in, avs_byteenable_in);
            end
            ADDR_CELL_CFG1: begin
               cell_cfg1_r <= apply_be(cell_cfg1_r, avs_writedata_in, avs_byteenable_in);
            end
            ADDR_CELL_CFG2: begin
               cell_cfg2_r <= apply_be(cell_cfg2_r, avs_writedata_in,
                                       avs_byteenable_in) & CELL_CFG2_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************************
   // Input cells
   // ***************************************************
   clm_in_cfg_type ded_cfg;
   clm_in_cfg_type pin_cfg;

   assign ded_cfg.capture_enable_sel = input_cfg_r[IN_DED_CAPTURE_BIT];
   assign ded_cfg.latch_sel          = input_cfg_r[IN_DED_LATCH_BIT];
   assign pin_cfg.capture_enable_sel = input_cfg_r[IN_PIN_CAPTURE_BIT];
   assign pin_cfg.latch_sel          = input_cfg_r[IN_PIN_LATCH_BIT];

   clm_input_group #(.W(N_DED)) u_dedicated_input_cell (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .cfg_in       (ded_cfg),
      .cap_level_in (input_capture_clock_in),
      .cap_rise_in  (icap_rise),
      .pins_in      (ded_pins_in),
      .cells_out    (ded_cells_out)
   );

   clm_input_group #(.W(N_OUT)) u_pin_input_cell (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .cfg_in       (pin_cfg),
      .cap_level_in (input_capture_clock_in),
      .cap_rise_in  (icap_rise),
      .pins_in      (io_pins_in),
      .cells_out    (pin_cells_out)
   );

   // ***************************************************
   // Output and buried cells
   // ***************************************************
   logic [4*N_CELLS-1:0] cell_cfg_all;
   logic [N_CELLS-1:0]   cell_values;
   clm_cell_cfg_type     cell_cfg [N_CELLS];

   // Slot k holds buried cell k for k below 8, else output cell k + 6.
   assign cell_cfg_all = {cell_cfg2_r[7:0], cell_cfg1_r, cell_cfg0_r};

   for (genvar k = 0; k < N_CELLS; k++) begin : g_cell
      assign cell_cfg[k] = clm_cell_cfg_type'(cell_cfg_all[4*k +: 4]);

      clm_cell u_cell (
         .clk_in       (clk_in),
         .reset_in     (reset_in),
         .clear_in     (clear_all),
         .cfg_in       (cell_cfg[k]),
         .data_in      (data_terms_in[k]),
         .enable_in    (enable_terms_in[k]),
         .oc_rise_in   (oc_rise),
         .reg_out      (cell_regs[k]),
         .value_out    (cell_values[k])
      );
   end

   // All cell values, buried and output, go back to the array.
   assign cell_feedback_out = cell_values;

   // ***************************************************
   // Pin drivers
   // ***************************************************
   for (genvar p = 0; p < N_OUT; p++) begin : g_pin
      // The pad buffer inverts, so a cleared register reads as one at any polarity.
      assign io_pins_out[p] = ~cell_values[N_BURIED + p];
   end

   assign io_pins_oe_out         = oe_terms_in;
   assign pin_feedback_valid_out = oe_terms_in;

endmodule

// file: tb/clm_fabric_props.sv
module clm_fabric_props
   import clm_pkg::*;
(
   input wire logic             clk_in,                 // Clock.
   input wire logic             reset_in,               // Reset.
   input wire logic [7:0]       avs_address_in,         // Address.
   input wire logic             avs_read_in,            // Read.
   input wire logic             avs_write_in,           // Write.
   input wire logic [31:0]      avs_writedata_in,       // Write data.
   input wire logic [3:0]       avs_byteenable_in,      // Lanes.
   input wire logic             avs_waitrequest_out,    // Stall.
   input wire logic             input_capture_clock_in, // Capture clock.
   input wire logic [N_DED-1:0] ded_pins_in,            // Pins.
   input wire logic [N_DED-1:0] ded_cells_out,          // Cells.
   input wire logic [N_OUT-1:0] oe_terms_in,            // Enable terms.
   input wire logic [N_OUT-1:0] io_pins_oe_out,         // Drive enables.
   input wire logic [N_OUT-1:0] pin_feedback_valid_out, // Feedback valid.
   input wire logic             reset_term_in,          // Reset term.
   input wire logic             pwrup_busy_out          // Clear busy.
);
   // ***************************************************
   // Shadow of the dedicated group mode and clear length
   // ***************************************************
   logic [1:0]  mode_r;
   logic [11:0] busy_cnt_r;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mode_r <= 2'h3;
      end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == ADDR_INPUT_CFG
                   && avs_byteenable_in[0]) begin
         mode_r <= avs_writedata_in[1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         busy_cnt_r <= 12'h000;
      end else if (pwrup_busy_out) begin
         busy_cnt_r <= busy_cnt_r + 12'h001;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   a_wait_once: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("waitrequest held more than one cycle");
   a_oe_terms: assert property (io_pins_oe_out == oe_terms_in)
      else $error("pin drive enable differs from its term");
   a_fb_valid: assert property (pin_feedback_valid_out == io_pins_oe_out)
      else $error("pin feedback valid differs from drive enable");
   a_busy_max: assert property (pwrup_busy_out |-> busy_cnt_r <= PWRUP_CYCLES + 1)
      else $error("power-up clear too long");
   a_busy_min: assert property (
      $fell(pwrup_busy_out) |-> busy_cnt_r >= PWRUP_CYCLES - 1)
      else $error("power-up clear too short");
   a_in_direct: assert property (mode_r == 2'h3 |-> ded_cells_out == ded_pins_in)
      else $error("direct group does not pass pins");
   a_in_transp: assert property (
      mode_r == 2'h0 && input_capture_clock_in && $past(input_capture_clock_in)
      |-> ded_cells_out == ded_pins_in)
      else $error("latch not transparent while clock high");
   a_in_hold: assert property (
      (!input_capture_clock_in && mode_r == 2'h0 && $stable(mode_r)) [*3]
      |-> $stable(ded_cells_out))
      else $error("latch changed while clock low");
   a_in_reg: assert property (
      mode_r == 2'h2 && input_capture_clock_in && !$past(input_capture_clock_in)
      |=> ded_cells_out == $past(ded_pins_in))
      else $error("register missed capture clock rise");

   c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
   c_reg_rise: cover property (mode_r == 2'h2 && $rose(input_capture_clock_in));
   c_clear_end: cover property ($fell(pwrup_busy_out));
   c_reset_term: cover property (reset_term_in);
endmodule

bind clm_fabric clm_fabric_props u_props (.clk_in, .reset_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
   .input_capture_clock_in, .ded_pins_in, .ded_cells_out, .oe_terms_in, .io_pins_oe_out,
   .pin_feedback_valid_out, .reset_term_in, .pwrup_busy_out);

// file: tb/clm_board.sv
module clm_board
   import clm_pkg::*;
(
   input  wire logic [N_OUT-1:0] drive_in, // Device drive values.
   input  wire logic [N_OUT-1:0] oe_in,    // Device drive enables.
   input  wire logic [N_OUT-1:0] board_in, // Board drive values.
   output logic      [N_OUT-1:0] pad_out   // Resolved pad levels.
);
   // The board backs off wherever the device drives, so a pad never fights.
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         pad_out[i] = oe_in[i] ? drive_in[i] : board_in[i];
      end
   end
endmodule

// file: tb/tb_clm_fabric.sv
module tb_clm_fabric
   import clm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
   int                 fails = 0;
   int                 compares = 0;
   logic               clk_in = 1'h0;
   logic               reset_in = 1'h1;
   logic [7:0]         avs_address_in = 8'h00;
   logic               avs_read_in = 1'h0;
   logic               avs_write_in = 1'h0;
   logic [31:0]        avs_writedata_in = 32'h0000_0000;
   logic [3:0]         avs_byteenable_in = 4'hF;
   logic [31:0]        avs_readdata_out, q;
   logic               avs_waitrequest_out, pwrup_busy_out;
   logic               input_capture_clock_in = 1'h0;
   logic               shared_output_clock_in = 1'h0;
   logic               reset_term_in = 1'h0;
   logic [N_DED-1:0]   ded_pins_in = '0;
   logic [N_DED-1:0]   ded_cells_out;
   logic [N_OUT-1:0]   io_pins_in, io_pins_out, io_pins_oe_out, pin_cells_out, pin_fb_valid;
   logic [N_OUT-1:0]   oe_terms_in = '0;
   logic [N_OUT-1:0]   board = '0;
   logic [N_CELLS-1:0] data_terms_in = '0;
   logic [N_CELLS-1:0] enable_terms_in = '0;
   logic [N_CELLS-1:0] cell_feedback_out;
   logic [1:0]         mcode [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
   logic [9:0]         pat [3] = '{10'h155, 10'h2AA, 10'h0F0};
   int                 sel [4][3] = '{'{0, 1, 2}, '{0, 1, 1}, '{0, 0, 0}, '{0, 1, 2}};

   always #2.5 clk_in = ~clk_in;

   clm_fabric dut (.clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .input_capture_clock_in, .shared_output_clock_in, .ded_pins_in, .io_pins_in,
      .io_pins_out, .io_pins_oe_out, .data_terms_in, .enable_terms_in, .oe_terms_in,
      .reset_term_in, .ded_cells_out, .pin_cells_out, .pin_feedback_valid_out(pin_fb_valid),
      .cell_feedback_out, .pwrup_busy_out);
   clm_board board_model (.drive_in(io_pins_out), .oe_in(io_pins_oe_out), .board_in(board),
      .pad_out(io_pins_in));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The request is held until waitrequest is seen low; a slave that never answers ends the run.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= b;
      avs_write_in <= w;
      avs_read_in <= ~w;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'h0) begin
         n++;
         if (n > 20) begin
            fails++;
            report_and_stop();
         end
         @(posedge clk_in);
      end
      q = avs_readdata_out;
      avs_write_in <= 1'h0;
      avs_read_in <= 1'h0;
      @(posedge clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      bus(1'h0, a, 32'h0000_0000, 4'hF);
      `CHK("register", ex, q)
   endtask

   task automatic cfg(input logic [3:0] n);
      wr(ADDR_CELL_CFG0, {CELL_CFG_RESET[31:4], n});
      wr(ADDR_CELL_CFG1, {CELL_CFG_RESET[31:4], n});
   endtask

   // Drives buried cell 0 and output cell 14 alike.
   task automatic drv(input logic d, input logic e, input logic o);
      data_terms_in <= {9'h000, d, 7'h00, d};
      enable_terms_in <= {9'h000, e, 7'h00, e};
      shared_output_clock_in <= o;
      tick(2);
   endtask

   task automatic chk(input logic e);
      `CHK("cells", {e, e}, {cell_feedback_out[8], cell_feedback_out[0]})
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (pwrup_busy_out !== 1'h0) begin
         n++;
         if (n > PWRUP_CYCLES + 100) begin
            fails++;
            report_and_stop();
         end
         @(posedge clk_in);
      end
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      tick(5);
      reset_in <= 1'h0;
      rd(ADDR_INPUT_CFG, INPUT_CFG_RESET);
      rd(ADDR_CELL_CFG0, CELL_CFG_RESET);
      rd(ADDR_CELL_CFG1, CELL_CFG_RESET);
      rd(ADDR_CELL_CFG2, CELL_CFG2_RESET);
      rd(ADDR_STATUS, 32'h0004_0000);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(8'h14, 32'h0000_0000);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rd(ADDR_STATUS, 32'h0004_0000);
      wr(ADDR_CELL_CFG2, 32'hFFFF_FF66);
      rd(ADDR_CELL_CFG2, 32'h0000_0066);
      bus(1'h1, ADDR_INPUT_CFG, 32'h0000_0000, 4'h2);
      rd(ADDR_INPUT_CFG, INPUT_CFG_RESET);
      wait_idle();
      rd(ADDR_STATUS, 32'h0000_0000);
      $display("registers done");
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_INPUT_CFG, {28'h000_0000, mcode[m], mcode[m]});
         input_capture_clock_in <= 1'h0;
         ded_pins_in <= pat[0];
         board <= pat[0];
         tick(3);
         input_capture_clock_in <= 1'h1;
         tick(3);
         `CHK("ded", pat[sel[m][0]], ded_cells_out)
         `CHK("pin", pat[sel[m][0]], pin_cells_out)
         ded_pins_in <= pat[1];
         board <= pat[1];
         tick(2);
         `CHK("ded", pat[sel[m][1]], ded_cells_out)
         `CHK("pin", pat[sel[m][1]], pin_cells_out)
         input_capture_clock_in <= 1'h0;
         tick(2);
         ded_pins_in <= pat[2];
         board <= pat[2];
         tick(2);
         `CHK("ded", pat[sel[m][2]], ded_cells_out)
         `CHK("pin", pat[sel[m][2]], pin_cells_out)
      end
      wr(ADDR_INPUT_CFG, INPUT_CFG_RESET);
      $display("input groups done");
      oe_terms_in <= 10'h2A5;
      data_terms_in <= {10'h0F0, 8'h00};
      board <= 10'h3FF;
      tick(2);
      `CHK("oe", 10'h2A5, io_pins_oe_out)
      `CHK("drive", 10'h00F, io_pins_out)
      `CHK("direct fb", 10'h3F0, cell_feedback_out[17:8])
      `CHK("pin fb", (10'h2A5 & 10'h00F) | (~10'h2A5 & 10'h3FF), pin_cells_out)
      $display("pins done");
      cfg(4'h6);
      drv(1'h1, 1'h0, 1'h0);
      chk(1'h0);
      `CHK("pin0", 1'h1, io_pins_out[0])
      cfg(4'h8);
      drv(1'h1, 1'h1, 1'h0);
      drv(1'h1, 1'h1, 1'h1);
      chk(1'h1);
      drv(1'h0, 1'h0, 1'h0);
      drv(1'h0, 1'h0, 1'h1);
      chk(1'h1);
      cfg(4'h9);
      drv(1'h0, 1'h0, 1'h0);
      drv(1'h0, 1'h0, 1'h1);
      chk(1'h0);
      cfg(4'h2);
      drv(1'h0, 1'h0, 1'h0);
      drv(1'h0, 1'h1, 1'h0);
      chk(1'h1);
      drv(1'h1, 1'h1, 1'h1);
      chk(1'h1);
      reset_term_in <= 1'h1;
      tick(2);
      chk(1'h0);
      `CHK("pin0", 1'h1, io_pins_out[0])
      rd(ADDR_STATUS, 32'h0000_0000);
      reset_term_in <= 1'h0;
      $display("cells done");
      reset_in <= 1'h1;
      tick(5);
      reset_in <= 1'h0;
      rd(ADDR_INPUT_CFG, INPUT_CFG_RESET);
      cfg(4'h8);
      drv(1'h1, 1'h1, 1'h0);
      drv(1'h1, 1'h1, 1'h1);
      chk(1'h0);
      wait_idle();
      $display("second reset done");
      report_and_stop();
   end
endmodule
